/* File: include/stsel_cfg.svh */
// Purpose: constants for the status byte selector
// Assumes: 100 MHz clock, byte-wide register port
// Notes: offsets are register indexes on the plain port
// Functional notes
// [RL1] hours counter ticks every 250 ms, bit7 zero
// [RL2] selectors 4..8 give hours counter slices
// [RL3] selectors 9..11 give power-on counter slices
// [RL4] power-on counter saturates at 131071
// [RL5] selector 12 gives inputs and mirror flag
// [RL6] selector 13 gives laser value bits 9..2
// [RL7] host fixes laser by readback then write
// [RL8] selector 14 third digit, 2 major-minor
// [RL9] selectors 15..31 read zero
// [RL10] selectors 32..63 give configuration bytes
// [RL11] two-byte values stored low slice first
// [RL12] serial number in selectors 36..39
// [RL13] selector 60 holds camera flags
// [RL14] selector 63 holds format version one
// [RL15] selector register bit7 reads zero
// [RL16] host never writes no-FIFO mode register
// [RL17] threshold register sets peak detection level
// [RL18] any other selector reads zero
`ifndef STSEL_CFG_SVH
`define STSEL_CFG_SVH
`define STSEL_OFF_SELECT 8'h11
`define STSEL_OFF_NOFIFO 8'h18
`define STSEL_OFF_THRESH 8'h1b
`define STSEL_OFF_STATUS 8'h1f
`define STSEL_OFF_CFG_ADDR 8'h70
`define STSEL_OFF_CFG_DATA 8'h71
`define STSEL_OFF_FW 8'h72
`define STSEL_RST_SELECT 8'h00
`define STSEL_RST_NOFIFO 8'h00
`define STSEL_RST_THRESH 8'h40
`define STSEL_TICK_MS 250
`define STSEL_CLK_KHZ 100000
`define STSEL_TICK_CYC (`STSEL_TICK_MS * `STSEL_CLK_KHZ)
`define STSEL_PON_MAX 17'h1ffff
`define STSEL_CFG_BASE 8'h20
`define STSEL_CFG_VER 7'h01
`define STSEL_CFG_VER_IDX 5'h1f
`endif

/* File: include/stsel_pkg.sv */
package stsel_pkg;
   typedef logic [6:0] stsel_slice_t;
   typedef enum logic [1:0] {
      STSEL_GRP_LIVE = 2'b00,
      STSEL_GRP_ZERO = 2'b01,
      STSEL_GRP_CFG = 2'b11
   } stsel_grp_e;
endpackage

/* File: include/stsel_cfg_if.sv */
`timescale 1ns/1ps
// carries configuration store write and read port
interface stsel_cfg_if;
   logic we;
   logic [4:0] waddr;
   logic [6:0] wdata;
   logic [4:0] raddr;
   logic [6:0] rdata;
   modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
   modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* File: design/stsel_cfg_store.sv */
`timescale 1ns/1ps
// Purpose: 32 slot configuration store, 7 bits per slot
// Assumes: written by software at start-up
// Notes: slot 31 is fixed to the format version
module stsel_cfg_store
   import stsel_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // store port
   stsel_cfg_if.store cfg
);
   `include "stsel_cfg.svh"
   logic [6:0] mem_q [32];

   // one flop row per slot; version slot is read only
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_slot
         always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               mem_q[g] <= 7'h00;
            end else if (cfg.we && cfg.waddr == 5'(g) && 5'(g) != `STSEL_CFG_VER_IDX) begin
               mem_q[g] <= cfg.wdata; // see [RL11] see [RL12] see [RL13]
            end
         end
      end
   endgenerate

   // version is a constant so software cannot break the format
   always_comb begin
      if (cfg.raddr == `STSEL_CFG_VER_IDX) begin
         cfg.rdata = `STSEL_CFG_VER; // see [RL14]
      end else if (cfg.raddr == 5'd29 || cfg.raddr == 5'd30) begin
         cfg.rdata = 7'h00; // see [RL14]
      end else if (cfg.raddr == 5'd28) begin
         cfg.rdata = {3'h0, mem_q[28][3:0]}; // see [RL13]
      end else begin
         cfg.rdata = mem_q[cfg.raddr]; // see [RL10]
      end
   end
endmodule

/* File: design/stsel_top.sv */
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Purpose: status byte selector feeding the scan packet status byte
// Assumes: single 100 MHz clock, plain register port, read data one cycle later
// Notes: unmapped register reads return zero
`include "stsel_cfg.svh"
module stsel_top
   import stsel_pkg::*;
#(
   parameter int unsigned TICK_CYC = `STSEL_TICK_CYC
)(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // device state
   input wire logic running_i,
   input wire logic power_on_pulse_i,
   input wire logic dig_in1_i,
   input wire logic dig_in2_i,
   input wire logic mirror_fitted_i,
   input wire logic [9:0] laser_auto_i,
   input wire logic [6:0] fw_major_minor_i,
   input wire logic [6:0] fw_third_i,
   // status byte and control outputs
   output logic [7:0] status_byte_o,
   output logic no_fifo_mode_o,
   output logic [7:0] peak_threshold_o
);
   // selector map of the status byte:
   //   0x00 0x01 0x03   outside this block, read zero
   //   0x02             firmware major*10+minor
   //   0x04..0x08       hours counter, 7-bit slices, lowest first
   //   0x09..0x0b       power-on counter, 7-bit slices, lowest first
   //   0x0c             dig_in1 bit0, dig_in2 bit1, mirror flag bit2
   //   0x0d             laser control value bits 9..2
   //   0x0e             third firmware digit
   //   0x0f..0x1f       unassigned, zero
   //   0x20..0x3f       configuration store slots 0..31
   //   0x40..0x7f       unassigned, zero
   //
   // configuration slot layout, pairs low slice first:
   //   slots 0,1 horizontal pixels; 2,3 vertical pixels
   //   slots 4..7 serial number, four 7-bit slices
   //   slots 8..27 range and scan-width limits
   //   slot 28 camera flags in bits 3..0
   //   slots 29,30 read zero; slot 31 format version
   //
   // registers on the plain port:
   //   0x11 selector, 7 bits stored
   //   0x18 no-FIFO mode, kept for old host cards only
   //   0x1b peak detection threshold, resets to 0x40
   //   0x1f status byte readback
   //   0x70 store slot index, 0x71 store data, 0x72 firmware readback
   //
   // timing seen from the register port:
   //   a selector write at edge n moves select_q after n,
   //   status_q follows after edge n+1, so a read strobe
   //   at n+1 still returns the old byte; n+2 gives the new one
   //   read data stands for one cycle and is zero otherwise
   //   writes to unmapped offsets are dropped silently
   //
   // counters:
   //   tick_q counts cycles while running_i is high and wraps
   //   at TICK_CYC-1; each wrap is one 250 ms step of hours_q
   //   hours_q is 32 bits, so it wraps only after decades of running
   //   pon_q holds at its 17-bit ceiling rather than wrapping,
   //   so a long-lived unit never reports a small count
   //
   // limitation: selector 13 carries eight laser bits, so it is the
   // one byte whose bit7 may be set
   //

   logic [7:0] select_q;
   logic [7:0] nofifo_q;
   logic [7:0] thresh_q;
   logic [4:0] cfg_addr_q;
   logic [31:0] hours_q;
   logic [16:0] pon_q;
   logic [31:0] tick_q;
   logic [7:0] status_d;
   logic [7:0] status_q;
   logic [7:0] rdata_d;
   stsel_cfg_if cfg ();

   // group of a selector value; used only by the status byte selection
   function automatic stsel_grp_e grp_of(input logic [7:0] s);
      if (s >= `STSEL_CFG_BASE && s < 8'h40) begin
         return STSEL_GRP_CFG;
      end else if (s <= 8'h0e) begin
         return STSEL_GRP_LIVE;
      end else begin
         return STSEL_GRP_ZERO;
      end
   endfunction

   // one 7-bit slice as a status byte; bit7 is always clear
   function automatic logic [7:0] slice7(input stsel_slice_t v);
      return {1'b0, v};
   endfunction

   // selector register; bit7 is not stored so it can never read back set
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         select_q <= `STSEL_RST_SELECT;
      end else if (reg_wr_i && reg_addr_i == `STSEL_OFF_SELECT) begin
         select_q <= {1'b0, reg_wdata_i[6:0]}; // see [RL15]
      end
   end

   // no-FIFO mode register, kept only for legacy host cards
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         nofifo_q <= `STSEL_RST_NOFIFO;
      end else if (reg_wr_i && reg_addr_i == `STSEL_OFF_NOFIFO) begin
         nofifo_q <= reg_wdata_i; // see [RL16]
      end
   end

   // peak threshold; a bad value is undone by writing the reset value back
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         thresh_q <= `STSEL_RST_THRESH;
      end else if (reg_wr_i && reg_addr_i == `STSEL_OFF_THRESH) begin
         thresh_q <= reg_wdata_i; // see [RL17]
      end
   end

   // store slot index; only five bits, so slot numbers wrap at 32
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cfg_addr_q <= 5'h00;
      end else if (reg_wr_i && reg_addr_i == `STSEL_OFF_CFG_ADDR) begin
         cfg_addr_q <= reg_wdata_i[4:0];
      end
   end

   // store writes go through the address register then data register
   assign cfg.we = reg_wr_i && reg_addr_i == `STSEL_OFF_CFG_DATA;
   assign cfg.waddr = cfg_addr_q;
   assign cfg.wdata = reg_wdata_i[6:0];
   assign cfg.raddr = select_q[4:0];

   stsel_cfg_store u_store (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .cfg(cfg)
   );

   // cycle prescaler for the 250 ms step; it pauses, not clears, when stopped
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tick_q <= 32'h0;
      end else if (running_i) begin
         if (tick_q >= TICK_CYC - 1) begin
            tick_q <= 32'h0;
         end else begin
            tick_q <= tick_q + 32'h1;
         end
      end
   end

   // operating hours counter, one step per prescaler wrap
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hours_q <= 32'h0;
      end else if (running_i && tick_q >= TICK_CYC - 1) begin
         hours_q <= hours_q + 32'h1; // see [RL1]
      end
   end

   // power-on counter holds at its ceiling instead of wrapping
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pon_q <= 17'h0;
      end else if (power_on_pulse_i && pon_q != `STSEL_PON_MAX) begin
         pon_q <= pon_q + 17'h1; // see [RL4]
      end
   end

   // status byte selection; every byte but selector 13 keeps bit7 clear
   always_comb begin
      status_d = 8'h00;
      case (grp_of(select_q))
         STSEL_GRP_CFG: begin
            status_d = {1'b0, cfg.rdata}; // see [RL10]
         end
         STSEL_GRP_LIVE: begin
            case (select_q[3:0])
               4'd2: begin
                  status_d = slice7(fw_major_minor_i); // see [RL8]
               end
               4'd4: begin
                  status_d = slice7(hours_q[6:0]); // see [RL2] see [RL1]
               end
               4'd5: begin
                  status_d = slice7(hours_q[13:7]); // see [RL2]
               end
               4'd6: begin
                  status_d = slice7(hours_q[20:14]); // see [RL2]
               end
               4'd7: begin
                  status_d = slice7(hours_q[27:21]); // see [RL2]
               end
               4'd8: begin
                  status_d = {4'h0, hours_q[31:28]}; // see [RL2]
               end
               4'd9: begin
                  status_d = slice7(pon_q[6:0]); // see [RL3]
               end
               4'd10: begin
                  status_d = slice7(pon_q[13:7]); // see [RL3]
               end
               4'd11: begin
                  status_d = {5'h00, pon_q[16:14]}; // see [RL3]
               end
               4'd12: begin
                  status_d = {5'h00, mirror_fitted_i, dig_in2_i, dig_in1_i}; // see [RL5]
               end
               4'd13: begin
                  // the two lowest laser bits are dropped on purpose
                  status_d = laser_auto_i[9:2]; // see [RL6]
               end
               4'd14: begin
                  status_d = slice7(fw_third_i); // see [RL8]
               end
               default: begin
                  status_d = 8'h00; // see [RL18]
               end
            endcase
         end
         default: begin
            status_d = 8'h00; // see [RL9] see [RL18]
         end
      endcase
   end

   // status byte is registered so the packet sees a stable value
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         status_q <= 8'h00;
      end else begin
         status_q <= status_d;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      case (reg_addr_i)
         `STSEL_OFF_SELECT: begin
            rdata_d = select_q;
         end
         `STSEL_OFF_NOFIFO: begin
            rdata_d = nofifo_q;
         end
         `STSEL_OFF_THRESH: begin
            rdata_d = thresh_q;
         end
         `STSEL_OFF_STATUS: begin
            rdata_d = status_q;
         end
         `STSEL_OFF_CFG_ADDR: begin
            rdata_d = {3'h0, cfg_addr_q};
         end
         `STSEL_OFF_FW: begin
            rdata_d = slice7(fw_major_minor_i);
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

   assign status_byte_o = status_q;
   assign no_fifo_mode_o = nofifo_q[0];
   assign peak_threshold_o = thresh_q; // see [RL17]
endmodule

/* File: bench/stsel_host.sv */
// Purpose: host software model on the register port
// Assumes: strobes one cycle long, no wait states
// Notes: no-FIFO offset is only ever read
`timescale 1ns/1ps
module stsel_host (
   // clock
   input wire logic clk_i,
   // register port
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   input wire logic [7:0] reg_rdata_i
);
   // bus idle at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   // one write cycle; callers never aim it at 0x18
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      // data stands between this edge and the next; take it mid-cycle
      @(negedge clk_i);
      d = reg_rdata_i;
   endtask
endmodule

/* File: bench/stsel_checker.sv */
// Purpose: port assertions for the status byte selector
// Assumes: selector shadowed from register writes
// Notes: status byte lags the selector by one cycle
`timescale 1ns/1ps
module stsel_checker (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   // inputs and status byte
   input wire logic dig_in1_i,
   input wire logic dig_in2_i,
   input wire logic mirror_fitted_i,
   input wire logic [7:0] status_byte_o
);
   logic [6:0] sel_q;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // selector shadow; bit 7 is dropped on write
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         sel_q <= 7'h00;
      else if (reg_wr_i && reg_addr_i == 8'h11)
         sel_q <= reg_wdata_i[6:0];
   end
   // status byte follows selector and inputs of the cycle before
   a_hours_bit7: assert property ($past(sel_q) inside {[4:7]} |-> !status_byte_o[7])
      else $error("hours byte bit 7 set");
   a_hours_top: assert property ($past(sel_q) == 7'd8 |-> status_byte_o[7:4] == 4'h0)
      else $error("hours top slice too wide");
   a_pon_top: assert property ($past(sel_q) == 7'd11 |-> status_byte_o[7:3] == 5'h00)
      else $error("power-on top slice too wide");
   a_inputs_byte: assert property ($past(sel_q) == 7'd12 |-> status_byte_o ==
      {5'h00, $past(mirror_fitted_i), $past(dig_in2_i), $past(dig_in1_i)})
      else $error("input byte wrong");
   a_unassigned_zero: assert property ($past(sel_q) inside {[15:31], [64:127]}
      |-> status_byte_o == 8'h00)
      else $error("unassigned byte not zero");
   a_cfg_bit7: assert property ($past(sel_q) >= 7'd32 |-> !status_byte_o[7])
      else $error("config byte bit 7 set");
   a_cfg_version: assert property ($past(sel_q) == 7'd63 |-> status_byte_o == 8'h01)
      else $error("format version wrong");
   a_sel_bit7: assert property ($past(reg_rd_i && reg_addr_i == 8'h11) |-> !reg_rdata_o[7])
      else $error("selector bit 7 reads one");
endmodule
bind stsel_top stsel_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
   .reg_rdata_o(reg_rdata_o), .dig_in1_i(dig_in1_i), .dig_in2_i(dig_in2_i),
   .mirror_fitted_i(mirror_fitted_i), .status_byte_o(status_byte_o));

/* File: bench/tb_status_byte_selector.sv */
// Purpose: self-checking bench for the status byte selector
// Assumes: hours tick shortened to 4 cycles
// Notes: expected bytes are built from the selector layout
`timescale 1ns/1ps
module tb_status_byte_selector;
   logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, running_i, power_on_pulse_i, no_fifo_mode_o;
   logic dig_in1_i, dig_in2_i, mirror_fitted_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, status_byte_o, peak_threshold_o, rv;
   logic [9:0] laser_auto_i = 10'h2b7;
   logic [6:0] fw_major_minor_i = 7'd36;
   logic [6:0] fw_third_i = 7'd2;
   int num_errors = 0;
   int num_checks = 0;
   stsel_top #(.TICK_CYC(4)) u_stsel_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .running_i(running_i),
      .power_on_pulse_i(power_on_pulse_i), .dig_in1_i(dig_in1_i), .dig_in2_i(dig_in2_i),
      .mirror_fitted_i(mirror_fitted_i), .laser_auto_i(laser_auto_i),
      .fw_major_minor_i(fw_major_minor_i), .fw_third_i(fw_third_i),
      .status_byte_o(status_byte_o), .no_fifo_mode_o(no_fifo_mode_o),
      .peak_threshold_o(peak_threshold_o));
   stsel_host u_host (.clk_i(clk_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
      .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_rdata_i(reg_rdata_o));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // checks both the live byte and its register readback
   task automatic sel(input logic [7:0] s, input logic [7:0] exp);
      u_host.wr(8'h11, s);
      u_host.rd(8'h1f, rv);
      cmp(rv, exp);
      cmp(status_byte_o, exp);
   endtask
   task automatic close_out;
      if (num_errors == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // watchdog, far beyond the roughly one thousand cycles the run needs
   initial begin
      #200us;
      num_errors++;
      close_out();
   end
   initial begin
      rst_n_i = 1'b0;
      {running_i, power_on_pulse_i, dig_in1_i, dig_in2_i, mirror_fitted_i} = 5'h00;
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      u_host.rd(8'h1b, rv);
      cmp(rv, 8'h40);
      u_host.rd(8'h18, rv);
      cmp(rv | {7'h00, no_fifo_mode_o}, 8'h00);
      u_host.wr(8'h11, 8'hff);
      u_host.rd(8'h11, rv);
      cmp(rv, 8'h7f);
      u_host.wr(8'h1b, 8'h55);
      u_host.rd(8'h1b, rv);
      cmp(rv, 8'h55);
      cmp(peak_threshold_o, 8'h55);
      u_host.rd(8'h05, rv);
      cmp(rv, 8'h00);
      for (int s = 4; s <= 11; s++) sel(8'(s), 8'h00);
      // 520 cycles at a 4-cycle tick gives about 130 hours counts
      running_i <= 1'b1;
      repeat (520) @(posedge clk_i);
      running_i <= 1'b0;
      sel(8'd5, 8'h01);
      u_host.wr(8'h11, 8'h04);
      u_host.rd(8'h1f, rv);
      cmp(rv, 8'h02);
      repeat (3) begin
         power_on_pulse_i <= 1'b1;
         @(posedge clk_i);
         power_on_pulse_i <= 1'b0;
         @(posedge clk_i);
      end
      sel(8'd9, 8'h03);
      for (int i = 0; i < 8; i++) begin
         {mirror_fitted_i, dig_in2_i, dig_in1_i} <= 3'(i);
         sel(8'd12, 8'(i));
      end
      sel(8'd13, 8'had);
      sel(8'd2, 8'h24);
      sel(8'd14, 8'h02);
      for (int s = 15; s <= 64; s += 49) sel(8'(s), 8'h00);
      // bit 7 of each stored byte is written as one and must drop
      for (int k = 0; k < 28; k++) begin
         u_host.wr(8'h70, 8'(k));
         u_host.wr(8'h71, 8'(k) + 8'hd0);
         sel(8'(k) + 8'h20, 8'(k) + 8'h50);
      end
      u_host.wr(8'h70, 8'h1c);
      u_host.wr(8'h71, 8'h7f);
      sel(8'd60, 8'h0f);
      u_host.wr(8'h70, 8'h1f);
      u_host.wr(8'h71, 8'h33);
      sel(8'd63, 8'h01);
      close_out();
   end
endmodule
